/* hdl/alcc_filter.sv */
// Purpose: persistence filter for one comparator result
// Assumes: raw input already synchronised to clk
// Notes: result cleared while disabled
`timescale 1ns/10ps
`default_nettype none
module alcc_filter
  import alcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic raw,
  input wire logic [CNT_W-1:0] period,
  output logic result_ff
);
  // ----------------------------------------------------------------
  // persistence counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic nxt_result;
  localparam logic [CNT_W-1:0] ONE = 32'h0000_0001;

  always_comb begin
    nxt_cnt = '0;
    nxt_result = result_ff;
    if (!enable) begin
      nxt_result = 1'b0;
    end else if (raw != result_ff) begin
      if (cnt_ff + ONE >= period) begin
        nxt_result = raw;
      end else begin
        nxt_cnt = cnt_ff + ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      result_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      result_ff <= nxt_result;
    end
  end
endmodule
`default_nettype wire

/* hdl/alcc_pkg.sv */
// Purpose: shared constants and types for the ambient light comparator control block
// Assumes: 50 MHz system clock, 8-bit register port from the serial interface core
// Notes: filter base count is overridable at the top module
package alcc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int LIGHT_FILTER_TIME_BASE_MS = 80;
  localparam int LIGHT_FILTER_TIME_BASE_CYC = (LIGHT_FILTER_TIME_BASE_MS * (CLK_HZ / 1000));
  localparam int LIGHT_FILTER_TIME_MAX_SHIFT = 7;
  localparam int CNT_W = 32;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LED1_CURRENT_ADDR = 8'h1a;
  localparam logic [7:0] LIGHT_CMP_CONFIG_ADDR = 8'h1b;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // light_cmp_config fields
  localparam int LIGHT_FILTER_TIME_MSB = 7;
  localparam int LIGHT_FILTER_TIME_LSB = 5;
  localparam int FORCE_BIT = 4;
  localparam int L3_RESULT_BIT = 3;
  localparam int L2_RESULT_BIT = 2;
  localparam int L3_ENABLE_BIT = 1;
  localparam int L2_ENABLE_BIT = 0;

  // led1_current_reg fields and the light_cmp_config filter time reset
  localparam int SINK_CODE_MSB = 6;
  localparam int SINK_CODE_W = 7;
  localparam logic [SINK_CODE_W-1:0] SINK_CODE_RESET = 7'h00;
  localparam logic [2:0] LIGHT_FILTER_TIME_RESET = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } alcc_reg_req_t;

  typedef enum logic [1:0] {
    ALCC_LVL_NORMAL = 2'b00,
    ALCC_LVL_OFFICE = 2'b01,
    ALCC_LVL_DARK = 2'b11
  } alcc_level_t;

  typedef enum logic [1:0] {
    ALCC_ST_IDLE = 2'b00,
    ALCC_ST_CONV = 2'b01,
    ALCC_ST_DONE = 2'b11
  } alcc_state_t;

  // filter period in cycles for a 3-bit code
  function automatic logic [CNT_W-1:0] alcc_filter_cycles(input logic [CNT_W-1:0] base, input logic [2:0] code);
    alcc_filter_cycles = base << code;
  endfunction
endpackage

/* hdl/alcc_top.sv */
// Purpose: control and status for the first light sensor comparator pair and the led1 sink code
// Assumes: register requests come from the serial interface core on clk; comparator pins are asynchronous
// Notes: comparators run while the backlight is on or a forced read is in progress
`timescale 1ns/10ps
`default_nettype none
module alcc_top
  import alcc_pkg::*;
#(
  parameter int LIGHT_FILTER_TIME_BASE_CYCLES = LIGHT_FILTER_TIME_BASE_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire alcc_reg_req_t reg_req,
  output logic [7:0] reg_rdata_ff,
  input wire logic backlight_en,
  input wire logic level2_trip_pin,
  input wire logic level3_trip_pin,
  output logic [SINK_CODE_W-1:0] led1_sink_code_ff,
  output logic [2:0] light_filter_time_ff,
  output logic level2_enable_ff,
  output logic level3_enable_ff,
  output logic level2_result_out_ff,
  output logic level3_result_out_ff,
  output logic sensor_active_ff,
  output alcc_level_t backlight_level_ff
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (LIGHT_FILTER_TIME_BASE_CYCLES < 1 || LIGHT_FILTER_TIME_BASE_CYCLES >= (1 << (CNT_W - 1 - LIGHT_FILTER_TIME_MAX_SHIFT))) begin
      $error("alcc_top: LIGHT_FILTER_TIME_BASE_CYCLES out of range");
    end
  end

  localparam logic [CNT_W-1:0] BASE_CYC = LIGHT_FILTER_TIME_BASE_CYCLES[CNT_W-1:0];
  localparam logic [CNT_W-1:0] ONE = 32'h0000_0001;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic l2_meta_ff;
  logic l2_sync_ff;
  logic l3_meta_ff;
  logic l3_sync_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      l2_meta_ff <= 1'b0;
      l2_sync_ff <= 1'b0;
      l3_meta_ff <= 1'b0;
      l3_sync_ff <= 1'b0;
    end else begin
      l2_meta_ff <= level2_trip_pin;
      l2_sync_ff <= l2_meta_ff;
      l3_meta_ff <= level3_trip_pin;
      l3_sync_ff <= l3_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic wr_led1;
  logic wr_cfg;
  logic force_ff;
  logic force_clear;
  alcc_state_t state_ff;
  alcc_state_t nxt_state;
  logic level2_result;
  logic level3_result;

  assign wr_led1 = reg_req.wr && (reg_req.addr == LED1_CURRENT_ADDR);
  assign wr_cfg = reg_req.wr && (reg_req.addr == LIGHT_CMP_CONFIG_ADDR);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led1_sink_code_ff <= SINK_CODE_RESET;
    end else if (wr_led1) begin
      led1_sink_code_ff <= reg_req.wdata[SINK_CODE_MSB:0];
    end
  end

  // result bits are not written here; they come from the filters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      light_filter_time_ff <= LIGHT_FILTER_TIME_RESET;
      level3_enable_ff <= 1'b0;
      level2_enable_ff <= 1'b0;
    end else if (wr_cfg) begin
      light_filter_time_ff <= reg_req.wdata[LIGHT_FILTER_TIME_MSB:LIGHT_FILTER_TIME_LSB];
      level3_enable_ff <= reg_req.wdata[L3_ENABLE_BIT];
      level2_enable_ff <= reg_req.wdata[L2_ENABLE_BIT];
    end
  end

  // a software set in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      force_ff <= 1'b0;
    end else if (wr_cfg && reg_req.wdata[FORCE_BIT]) begin
      force_ff <= 1'b1;
    end else if (wr_cfg) begin
      force_ff <= 1'b0;
    end else if (force_clear) begin
      force_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // forced read sequencer
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] conv_cnt_ff;
  logic [CNT_W-1:0] nxt_conv_cnt;

  assign period = alcc_filter_cycles(BASE_CYC, light_filter_time_ff);
  assign force_clear = (state_ff == ALCC_ST_DONE);

  always_comb begin
    nxt_state = state_ff;
    nxt_conv_cnt = '0;
    case (state_ff)
      ALCC_ST_IDLE: begin
        if (force_ff && !backlight_en) begin
          nxt_state = ALCC_ST_CONV;
        end
      end
      ALCC_ST_CONV: begin
        if (backlight_en) begin
          nxt_state = ALCC_ST_IDLE;
        end else if (conv_cnt_ff + ONE >= period) begin
          nxt_state = ALCC_ST_DONE;
        end else begin
          nxt_conv_cnt = conv_cnt_ff + ONE;
        end
      end
      ALCC_ST_DONE: begin
        nxt_state = ALCC_ST_IDLE;
      end
      default: begin
        nxt_state = ALCC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ALCC_ST_IDLE;
      conv_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      conv_cnt_ff <= nxt_conv_cnt;
    end
  end

  // ----------------------------------------------------------------
  // comparator filters
  // ----------------------------------------------------------------
  logic run;
  assign run = backlight_en || (state_ff != ALCC_ST_IDLE);

  alcc_filter u_l2_filter (
    .clk(clk),
    .rstn(rstn),
    .enable(run && level2_enable_ff),
    .raw(l2_sync_ff),
    .period(period),
    .result_ff(level2_result)
  );

  alcc_filter u_l3_filter (
    .clk(clk),
    .rstn(rstn),
    .enable(run && level3_enable_ff),
    .raw(l3_sync_ff),
    .period(period),
    .result_ff(level3_result)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  alcc_level_t nxt_level;

  always_comb begin
    if (level3_result) begin
      nxt_level = ALCC_LVL_DARK;
    end else if (level2_result) begin
      nxt_level = ALCC_LVL_OFFICE;
    end else begin
      nxt_level = ALCC_LVL_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      backlight_level_ff <= ALCC_LVL_NORMAL;
      level2_result_out_ff <= 1'b0;
      level3_result_out_ff <= 1'b0;
      sensor_active_ff <= 1'b0;
    end else begin
      backlight_level_ff <= nxt_level;
      level2_result_out_ff <= level2_result;
      level3_result_out_ff <= level3_result;
      sensor_active_ff <= run;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  logic [7:0] cfg_view;
  always_comb begin
    cfg_view = DATA_ZERO;
    cfg_view[LIGHT_FILTER_TIME_MSB:LIGHT_FILTER_TIME_LSB] = light_filter_time_ff;
    cfg_view[FORCE_BIT] = force_ff;
    cfg_view[L3_RESULT_BIT] = level3_result;
    cfg_view[L2_RESULT_BIT] = level2_result;
    cfg_view[L3_ENABLE_BIT] = level3_enable_ff;
    cfg_view[L2_ENABLE_BIT] = level2_enable_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= DATA_ZERO;
    end else if (reg_req.rd) begin
      if (reg_req.addr == LED1_CURRENT_ADDR) begin
        reg_rdata_ff <= {1'b0, led1_sink_code_ff};
      end else if (reg_req.addr == LIGHT_CMP_CONFIG_ADDR) begin
        reg_rdata_ff <= cfg_view;
      end else begin
        reg_rdata_ff <= DATA_ZERO;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/alcc_light_sensor.sv */
// Purpose: light sensor and comparator pair seen from the block
// Assumes: light 0 bright, 1 office, 2 dark
// Notes: pins move a little after the edge that changes light
`timescale 1ns/10ps
`default_nettype none
module alcc_light_sensor (
  input wire logic [1:0] light,
  output logic level2_trip_pin,
  output logic level3_trip_pin
);
  // dark lies below both thresholds
  assign #2 level2_trip_pin = (light != 2'h0);
  assign #2 level3_trip_pin = (light == 2'h2);
endmodule
`default_nettype wire

/* testbench/alcc_props.sv */
// Purpose: port assertions for alcc_top
// Assumes: one clock domain
// Notes: bound at the foot
`timescale 1ns/10ps
`default_nettype none
module alcc_props
  import alcc_pkg::*;
#(
  parameter int LIGHT_FILTER_TIME_BASE_CYCLES = 8
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire alcc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic backlight_en,
  input wire logic level3_trip_pin,
  input wire logic [SINK_CODE_W-1:0] led1_sink_code_ff,
  input wire logic [2:0] light_filter_time_ff,
  input wire logic level2_enable_ff,
  input wire logic level3_enable_ff,
  input wire logic level2_result_out_ff,
  input wire logic level3_result_out_ff,
  input wire logic sensor_active_ff,
  input wire alcc_level_t backlight_level_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic wr_led = reg_req.wr && reg_req.addr == LED1_CURRENT_ADDR;
  wire logic wr_cfg = reg_req.wr && reg_req.addr == LIGHT_CMP_CONFIG_ADDR;
  wire logic rd_bad = reg_req.rd && reg_req.addr != LED1_CURRENT_ADDR && reg_req.addr != LIGHT_CMP_CONFIG_ADDR;
  chk_sink_write: assert property (wr_led |=> led1_sink_code_ff == $past(reg_req.wdata[6:0]))
    else $error("sink code not taken");
  chk_sink_hold: assert property (!wr_led |=> $stable(led1_sink_code_ff))
    else $error("sink code moved");
  chk_light_filter_time_write: assert property (wr_cfg |=> light_filter_time_ff == $past(reg_req.wdata[7:5]))
    else $error("filter code not taken");
  chk_l3_enable: assert property (wr_cfg |=> level3_enable_ff == $past(reg_req.wdata[1]))
    else $error("level3 enable wrong");
  chk_l2_enable: assert property (wr_cfg |=> level2_enable_ff == $past(reg_req.wdata[0]))
    else $error("level2 enable wrong");
  chk_unmapped_read: assert property (rd_bad |=> reg_rdata_ff == DATA_ZERO)
    else $error("unmapped read not zero");
  chk_rsv_read: assert property (reg_req.rd && reg_req.addr == LED1_CURRENT_ADDR |=> !reg_rdata_ff[7])
    else $error("reserved bit not zero");
  chk_l3_off_clear: assert property (!level3_enable_ff && !$past(level3_enable_ff) && !$past(level3_enable_ff, 2)
    |-> !level3_result_out_ff) else $error("level3 result while disabled");
  chk_l2_off_clear: assert property (!level2_enable_ff && !$past(level2_enable_ff) && !$past(level2_enable_ff, 2)
    |-> !level2_result_out_ff) else $error("level2 result while disabled");
  chk_normal_level: assert property (!level3_result_out_ff && !level2_result_out_ff
    |-> backlight_level_ff == ALCC_LVL_NORMAL) else $error("normal level not set");
  chk_dark_prio: assert property (level3_result_out_ff && $past(level3_result_out_ff)
    |-> backlight_level_ff == ALCC_LVL_DARK) else $error("level3 lost priority");
  chk_office_level: assert property (!level3_result_out_ff && !$past(level3_result_out_ff) && level2_result_out_ff
    && $past(level2_result_out_ff) |-> backlight_level_ff == ALCC_LVL_OFFICE) else $error("office not set");
  chk_filter_persist: assert property ($rose(level3_result_out_ff)
    |-> $past(level3_trip_pin, 5) && $past(level3_trip_pin, 9)) else $error("result ahead of filter");
  cover property ($rose(sensor_active_ff) && !backlight_en);
  cover property (backlight_level_ff == ALCC_LVL_DARK);
  cover property (backlight_level_ff == ALCC_LVL_OFFICE);
endmodule
bind alcc_top alcc_props #(.LIGHT_FILTER_TIME_BASE_CYCLES(LIGHT_FILTER_TIME_BASE_CYCLES)) u_props (.clk(clk), .rstn(rstn),
  .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff), .backlight_en(backlight_en), .level3_trip_pin(level3_trip_pin),
  .led1_sink_code_ff(led1_sink_code_ff), .light_filter_time_ff(light_filter_time_ff),
  .level2_enable_ff(level2_enable_ff), .level3_enable_ff(level3_enable_ff),
  .level2_result_out_ff(level2_result_out_ff), .level3_result_out_ff(level3_result_out_ff),
  .sensor_active_ff(sensor_active_ff), .backlight_level_ff(backlight_level_ff));
`default_nettype wire

/* testbench/ambient_light_comparator_ctrl_test.sv */
// Purpose: self-checking bench for alcc_top
// Assumes: filter base shortened to 8 cycles
// Notes: register port driven at the rising edge
`timescale 1ns/10ps
`default_nettype none
module ambient_light_comparator_ctrl_test;
  import alcc_pkg::*;
  localparam int BASE = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  alcc_reg_req_t reg_req = '0;
  logic backlight_en = 1'b0;
  logic [1:0] light = 2'h0;
  logic l2_pin, l3_pin, l2en, l3en, l2res, l3res, active;
  logic [7:0] rdata;
  logic [6:0] sink;
  logic [2:0] light_filter_time;
  alcc_level_t level;
  int errors = 0;
  int n_tests = 0;
  int seed = 66224;
  always #10 clk = ~clk;
  alcc_light_sensor sensor (.light(light), .level2_trip_pin(l2_pin), .level3_trip_pin(l3_pin));
  alcc_top #(.LIGHT_FILTER_TIME_BASE_CYCLES(BASE)) uut (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata_ff(rdata),
    .backlight_en(backlight_en), .level2_trip_pin(l2_pin), .level3_trip_pin(l3_pin), .led1_sink_code_ff(sink),
    .light_filter_time_ff(light_filter_time), .level2_enable_ff(l2en), .level3_enable_ff(l3en), .level2_result_out_ff(l2res),
    .level3_result_out_ff(l3res), .sensor_active_ff(active), .backlight_level_ff(level));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic int exp_period(input int code);
    return BASE << code;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_rd(input logic [7:0] m, input logic [7:0] v, input int lim);
    logic [7:0] d;
    int i;
    d = ~v;
    i = 0;
    while ((d & m) !== v && i < lim) begin
      rd(LIGHT_CMP_CONFIG_ADDR, d);
      i++;
    end
    check(d & m, v, "config poll");
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d, v;
    int k, n;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(LED1_CURRENT_ADDR, d); check(d, 8'h00, "sink reset");
    rd(LIGHT_CMP_CONFIG_ADDR, d); check(d, 8'h00, "config reset");
    for (k = 0; k < 10; k++) begin
      v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      wr(LED1_CURRENT_ADDR, v);
      rd(LED1_CURRENT_ADDR, d); check(d, {1'b0, v[6:0]}, "sink read");
      check({1'b0, sink}, {1'b0, v[6:0]}, "sink port");
      v = 8'($random(seed)) & 8'hef;
      wr(LIGHT_CMP_CONFIG_ADDR, v);
      rd(LIGHT_CMP_CONFIG_ADDR, d); check(d, v & 8'he3, "config read");
      check({light_filter_time, 3'h0, l3en, l2en}, {v[7:5], 3'h0, v[1:0]}, "config port");
    end
    wr(8'h1c, 8'hff);
    rd(8'h1c, d); check(d, 8'h00, "unmapped read");
    // forced read with backlight off
    light <= 2'h2;
    wr(LIGHT_CMP_CONFIG_ADDR, 8'h13);
    rd(LIGHT_CMP_CONFIG_ADDR, d); check({7'h0, d[4]}, 8'h01, "force held");
    check({7'h0, active}, 8'h01, "sensor running");
    wait_rd(8'h10, 8'h00, 20);
    // forced read ignored with backlight on
    @(posedge clk);
    backlight_en <= 1'b1;
    wr(LIGHT_CMP_CONFIG_ADDR, 8'h13);
    repeat (40) @(posedge clk);
    rd(LIGHT_CMP_CONFIG_ADDR, d); check({7'h0, d[4]}, 8'h01, "force ignored");
    wait_rd(8'h0c, 8'h0c, 30);
    check({6'h0, level}, {6'h0, ALCC_LVL_DARK}, "dark level");
    wr(LIGHT_CMP_CONFIG_ADDR, 8'h03);
    rd(LIGHT_CMP_CONFIG_ADDR, d); check(d, 8'h0f, "results kept");
    wr(LIGHT_CMP_CONFIG_ADDR, 8'h01);
    wait_rd(8'h0c, 8'h04, 30);
    repeat (3) @(posedge clk);
    #1 check({4'h0, l3res, l2res, level}, {4'h0, 2'b01, ALCC_LVL_OFFICE}, "office level");
    wr(LIGHT_CMP_CONFIG_ADDR, 8'h00);
    wait_rd(8'h0c, 8'h00, 10);
    repeat (2) @(posedge clk);
    #1 check({4'h0, l3res, l2res, level}, {4'h0, 2'b00, ALCC_LVL_NORMAL}, "normal level");
    // filter persistence per code
    for (k = 0; k < 8; k++) begin
      light <= 2'h0;
      wr(LIGHT_CMP_CONFIG_ADDR, {k[2:0], 5'h03});
      wait_rd(8'h0c, 8'h00, 600);
      @(posedge clk);
      light <= 2'h2;
      n = 0;
      while (l3res !== 1'b1 && n < 1100) begin
        @(posedge clk);
        #1 n++;
      end
      n_tests++;
      if (n < exp_period(k) || n > exp_period(k) + 8) begin
        errors++;
        $display("MISMATCH t=%0t filter delay %0d for code %0d", $time, n, k);
      end
    end
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("MISMATCH t=%0t run did not finish", $time);
    close_out();
  end
endmodule
`default_nettype wire
